// ### audio_and_iq_serial_ports_pkg.sv
// constants, types and framing helpers for the audio and baseband serial ports
package audio_and_iq_serial_ports_pkg;

	typedef enum logic [2:0] {
		FMT_STANDARD = 3'b000,
		FMT_LEFT = 3'b001,
		FMT_RIGHT = 3'b010,
		FMT_DSP = 3'b011,
		FMT_DSP_LEFT = 3'b100
	} frame_format_t;

	localparam int POS_W = 10;
	localparam int AUDIO_MAX_W = 24;
	localparam int BB_WORD_W = 16;

	localparam logic [7:0] OFS_AUDIO_CTRL = 8'h00;
	localparam logic [7:0] OFS_BB_CTRL = 8'h04;
	localparam logic [7:0] OFS_BB_DIV = 8'h08;
	localparam logic [7:0] OFS_BB_LEN = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	localparam int FMT_LSB = 0;
	localparam int FALL_BIT = 3;
	localparam int WLEN_LSB = 4;
	localparam int BB_EN_BIT = 6;
	localparam int BB_AM_BIT = 7;

	localparam logic [7:0] AUDIO_CTRL_RST = 8'h30;
	localparam logic [7:0] BB_CTRL_RST = 8'h00;
	localparam logic [7:0] BB_DIV_RST = 8'h03;
	localparam logic [POS_W-1:0] BB_LEN_RST = 10'h020;

	// word length codes 0..3 select 8, 16, 20, 24 bits
	function automatic int word_bits(input logic [1:0] code);
		word_bits = (code == 2'h0) ? 8 : (code == 2'h1) ? 16 : (code == 2'h2) ? 20 : 24;
	endfunction

	// bit offset into the word for the capture edge at position p of an interval
	function automatic int word_offset(input frame_format_t fmt, input int p, input int len,
		input int w);
		unique case (fmt)
			FMT_STANDARD: word_offset = p - 1;
			FMT_LEFT: word_offset = p;
			FMT_RIGHT: word_offset = p - (len - w);
			FMT_DSP: word_offset = p - 2;
			FMT_DSP_LEFT: word_offset = p - 1;
			default: word_offset = -1;
		endcase
	endfunction

	// outside the word the line is held low
	function automatic logic word_bit(input logic [AUDIO_MAX_W-1:0] word, input int w,
		input int idx);
		word_bit = (idx >= 0 && idx < w) ? word[w-1-idx] : 1'b0;
	endfunction

endpackage

// ### audio_and_iq_serial_ports.sv
// audio slave and baseband master serial ports with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module audio_and_iq_serial_ports (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic [31:0] hrdata_o,
	output logic hresp_o,
	input wire logic audio_bit_clock_i,
	input wire logic audio_frame_sync_i,
	output logic audio_serial_out_o,
	input wire logic [audio_and_iq_serial_ports_pkg::AUDIO_MAX_W-1:0] audio_left_i,
	input wire logic [audio_and_iq_serial_ports_pkg::AUDIO_MAX_W-1:0] audio_right_i,
	input wire logic audio_valid_i,
	output logic audio_ready_o,
	output logic baseband_bit_clock_o,
	output logic baseband_frame_sync_o,
	output logic in_phase_serial_out_o,
	output logic quadrature_serial_out_o,
	input wire logic [audio_and_iq_serial_ports_pkg::BB_WORD_W-1:0] bb_in_phase_i,
	input wire logic [audio_and_iq_serial_ports_pkg::BB_WORD_W-1:0] bb_quadrature_i,
	input wire logic bb_valid_i,
	output logic bb_ready_o,
	output logic baseband_am_mode_o
);
	import audio_and_iq_serial_ports_pkg::*;

	typedef struct packed {
		logic dp_valid;
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
		logic [7:0] audio_ctrl;
		logic [7:0] bb_ctrl;
		logic [7:0] bb_div;
		logic [POS_W-1:0] bb_len;
		logic [AUDIO_MAX_W-1:0] hold_left;
		logic [AUDIO_MAX_W-1:0] hold_right;
		logic req;
		logic ack_meta;
		logic ack_sync;
		logic lock_meta;
		logic lock_sync;
		logic [BB_WORD_W-1:0] bb_hold_i;
		logic [BB_WORD_W-1:0] bb_hold_q;
		logic bb_full;
		logic [BB_WORD_W-1:0] bb_act_i;
		logic [BB_WORD_W-1:0] bb_act_q;
		logic [7:0] bb_divc;
		logic [POS_W-1:0] bb_pos;
		logic bb_clk;
		logic bb_fs;
		logic bb_i_out;
		logic bb_q_out;
	} sys_state_t;

	typedef struct packed {
		logic rst_meta;
		logic rst;
		logic [7:0] cfg_meta;
		logic [7:0] cfg;
		logic req_meta;
		logic req;
		logic ack;
		logic fs_prev;
		logic [POS_W-1:0] cnt;
		logic [POS_W-1:0] len;
		logic [AUDIO_MAX_W-1:0] act_left;
		logic [AUDIO_MAX_W-1:0] act_right;
		logic [AUDIO_MAX_W-1:0] pend_right;
		logic out;
	} link_state_t;

	sys_state_t sys_ff;
	sys_state_t nxt_sys;
	link_state_t link_ff;
	link_state_t nxt_link;
	logic out_neg_ff;

	// register slave and baseband master, system clock
	always_comb begin
		frame_format_t bfmt;
		logic bb_dsp;
		logic [7:0] lim;
		logic launch;
		logic [POS_W-1:0] pos;
		int idx;
		logic [AUDIO_MAX_W-1:0] wi;
		logic [AUDIO_MAX_W-1:0] wq;
		nxt_sys = sys_ff;
		bfmt = FMT_STANDARD;
		bb_dsp = 1'b0;
		lim = 8'h00;
		launch = 1'b0;
		pos = sys_ff.bb_pos;
		idx = 0;
		wi = '0;
		wq = '0;

		nxt_sys.ack_meta = link_ff.ack;
		nxt_sys.ack_sync = sys_ff.ack_meta;
		nxt_sys.lock_meta = (link_ff.len != '0);
		nxt_sys.lock_sync = sys_ff.lock_meta;

		if (sys_ff.dp_valid && sys_ff.dp_write) begin
			unique case (sys_ff.dp_addr)
				OFS_AUDIO_CTRL: nxt_sys.audio_ctrl = hwdata_i[7:0];
				OFS_BB_CTRL: nxt_sys.bb_ctrl = hwdata_i[7:0];
				OFS_BB_DIV: nxt_sys.bb_div = hwdata_i[7:0];
				OFS_BB_LEN: nxt_sys.bb_len = hwdata_i[POS_W-1:0];
				default: ;
			endcase
		end

		nxt_sys.dp_valid = hsel_i && hready_i && htrans_i[1];
		nxt_sys.dp_write = hwrite_i;
		nxt_sys.dp_addr = haddr_i[7:0];
		if (nxt_sys.dp_valid && !hwrite_i) begin
			// read mux looks at next values so a write just before is seen
			unique case (haddr_i[7:0])
				OFS_AUDIO_CTRL: nxt_sys.rdata = {24'h000000, nxt_sys.audio_ctrl};
				OFS_BB_CTRL: nxt_sys.rdata = {24'h000000, nxt_sys.bb_ctrl};
				OFS_BB_DIV: nxt_sys.rdata = {24'h000000, nxt_sys.bb_div};
				OFS_BB_LEN: nxt_sys.rdata = {22'h000000, nxt_sys.bb_len};
				OFS_STATUS: nxt_sys.rdata = {29'h00000000, sys_ff.lock_sync,
					sys_ff.bb_full, sys_ff.req ^ sys_ff.ack_sync};
				default: nxt_sys.rdata = 32'h00000000;
			endcase
		end

		// one pair in flight; link side takes it and answers with its toggle
		if (audio_valid_i && (sys_ff.req == sys_ff.ack_sync)) begin
			nxt_sys.hold_left = audio_left_i;
			nxt_sys.hold_right = audio_right_i;
			nxt_sys.req = ~sys_ff.req;
		end

		if (bb_valid_i && !sys_ff.bb_full) begin
			nxt_sys.bb_hold_i = bb_in_phase_i;
			nxt_sys.bb_hold_q = bb_quadrature_i;
			nxt_sys.bb_full = 1'b1;
		end

		bfmt = frame_format_t'(sys_ff.bb_ctrl[FMT_LSB +: 3]);
		bb_dsp = (bfmt == FMT_DSP) || (bfmt == FMT_DSP_LEFT);
		lim = (sys_ff.bb_div == 8'h00) ? 8'h00 : sys_ff.bb_div - 8'h01;
		if (!sys_ff.bb_ctrl[BB_EN_BIT]) begin
			nxt_sys.bb_divc = 8'h00;
			nxt_sys.bb_pos = sys_ff.bb_len - 10'h001;
			nxt_sys.bb_clk = 1'b0;
			nxt_sys.bb_fs = 1'b0;
			nxt_sys.bb_i_out = 1'b0;
			nxt_sys.bb_q_out = 1'b0;
		end else if (sys_ff.bb_divc >= lim) begin
			nxt_sys.bb_divc = 8'h00;
			nxt_sys.bb_clk = ~sys_ff.bb_clk;
			// data and frame change on the edge opposite the capture edge
			launch = sys_ff.bb_ctrl[FALL_BIT] ? !sys_ff.bb_clk : sys_ff.bb_clk;
		end else begin
			nxt_sys.bb_divc = sys_ff.bb_divc + 8'h01;
		end

		if (launch) begin
			pos = (sys_ff.bb_pos + 10'h001 >= sys_ff.bb_len) ? '0 : sys_ff.bb_pos + 10'h001;
			nxt_sys.bb_pos = pos;
			if (pos == '0) begin
				if (sys_ff.bb_full) begin
					nxt_sys.bb_act_i = sys_ff.bb_hold_i;
					nxt_sys.bb_act_q = sys_ff.bb_hold_q;
					nxt_sys.bb_full = 1'b0;
				end
				// frame marks each complex sample
				nxt_sys.bb_fs = bb_dsp ? 1'b1 : ~sys_ff.bb_fs;
			end else if (bb_dsp) begin
				nxt_sys.bb_fs = 1'b0;
			end
			idx = word_offset(bfmt, int'(pos), int'(sys_ff.bb_len), BB_WORD_W);
			wi = {8'h00, nxt_sys.bb_act_i};
			wq = {8'h00, nxt_sys.bb_act_q};
			nxt_sys.bb_i_out = word_bit(wi, BB_WORD_W, idx);
			nxt_sys.bb_q_out = word_bit(wq, BB_WORD_W, idx);
		end

		if (reset_i) begin
			nxt_sys = '0;
			nxt_sys.audio_ctrl = AUDIO_CTRL_RST;
			nxt_sys.bb_ctrl = BB_CTRL_RST;
			nxt_sys.bb_div = BB_DIV_RST;
			nxt_sys.bb_len = BB_LEN_RST;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		sys_ff <= nxt_sys;
	end

	// audio slave, clocked by the partner's bit clock
	always_comb begin
		frame_format_t fmt;
		logic dsp;
		logic fs;
		logic start;
		logic left_lvl;
		logic pending;
		logic [POS_W-1:0] cur;
		logic [POS_W-1:0] nx;
		logic nlevel;
		int w;
		int idx;
		nxt_link = link_ff;
		fmt = FMT_STANDARD;
		dsp = 1'b0;
		fs = 1'b0;
		start = 1'b0;
		left_lvl = 1'b0;
		pending = 1'b0;
		cur = '0;
		nx = '0;
		nlevel = 1'b0;
		w = 0;
		idx = 0;
		nxt_link.rst_meta = reset_i;
		nxt_link.rst = link_ff.rst_meta;
		// static settings; change them only while the port is unused
		nxt_link.cfg_meta = sys_ff.audio_ctrl;
		nxt_link.cfg = link_ff.cfg_meta;
		nxt_link.req_meta = sys_ff.req;
		nxt_link.req = link_ff.req_meta;

		fmt = frame_format_t'(link_ff.cfg[FMT_LSB +: 3]);
		dsp = (fmt == FMT_DSP) || (fmt == FMT_DSP_LEFT);
		w = word_bits(link_ff.cfg[WLEN_LSB +: 2]);
		fs = audio_frame_sync_i;
		left_lvl = (fmt != FMT_STANDARD);
		pending = (link_ff.req != link_ff.ack);
		start = dsp ? (fs && !link_ff.fs_prev) : (fs != link_ff.fs_prev);
		nxt_link.fs_prev = fs;

		cur = (link_ff.cnt == '1) ? link_ff.cnt : link_ff.cnt + 10'h001;
		if (start) begin
			cur = '0;
			// interval length follows the external frame, up to 1023 edges; a longer one reads as 0
			nxt_link.len = link_ff.cnt + 10'h001;
		end
		nxt_link.cnt = cur;

		if (start && dsp) begin
			if (pending) begin
				nxt_link.act_left = sys_ff.hold_left;
				nxt_link.act_right = sys_ff.hold_right;
				nxt_link.ack = ~link_ff.ack;
			end
		end else if (start && (fs != left_lvl)) begin
			// left word done: new left goes in, its right waits for its slot
			if (pending) begin
				nxt_link.act_left = sys_ff.hold_left;
				nxt_link.pend_right = sys_ff.hold_right;
				nxt_link.ack = ~link_ff.ack;
			end
		end else if (start) begin
			nxt_link.act_right = link_ff.pend_right;
		end

		// predict the next edge so the first-edge formats are ready in time
		nx = cur + 10'h001;
		nlevel = fs;
		if (nxt_link.len != '0 && nx >= nxt_link.len) begin
			nx = '0;
			nlevel = ~fs;
		end
		idx = word_offset(fmt, int'(nx), int'(nxt_link.len), w);
		if (dsp) begin
			nxt_link.out = (idx < w) ? word_bit(nxt_link.act_left, w, idx) :
				word_bit(nxt_link.act_right, w, idx - w);
		end else begin
			nxt_link.out = word_bit((nlevel == left_lvl) ? nxt_link.act_left :
				nxt_link.act_right, w, idx);
		end

		if (link_ff.rst) begin
			nxt_link = '0;
			nxt_link.rst_meta = reset_i;
			nxt_link.rst = link_ff.rst_meta;
			nxt_link.cfg_meta = sys_ff.audio_ctrl;
			nxt_link.cfg = link_ff.cfg_meta;
			nxt_link.req_meta = sys_ff.req;
			nxt_link.req = link_ff.req_meta;
			nxt_link.ack = link_ff.req;
			nxt_link.fs_prev = audio_frame_sync_i;
		end
	end

	always_ff @(posedge audio_bit_clock_i) begin
		link_ff <= nxt_link;
	end

	// half a bit later, so rising-edge capture sees a settled bit
	always_ff @(negedge audio_bit_clock_i) begin
		if (link_ff.rst) begin
			out_neg_ff <= 1'b0;
		end else begin
			out_neg_ff <= link_ff.out;
		end
	end

	assign audio_serial_out_o = link_ff.cfg[FALL_BIT] ? link_ff.out : out_neg_ff;
	assign audio_ready_o = (sys_ff.req == sys_ff.ack_sync);
	assign bb_ready_o = !sys_ff.bb_full;
	assign baseband_bit_clock_o = sys_ff.bb_clk;
	assign baseband_frame_sync_o = sys_ff.bb_fs;
	assign in_phase_serial_out_o = sys_ff.bb_i_out;
	assign quadrature_serial_out_o = sys_ff.bb_q_out;
	// upstream decimator picks the narrow channel when set
	assign baseband_am_mode_o = sys_ff.bb_ctrl[BB_AM_BIT];
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = sys_ff.rdata;

endmodule
`default_nettype wire

// ### audio_and_iq_serial_ports_asserts.sv
// concurrent checks on the serial port block's pins
`timescale 1ns/1ps
`default_nettype none
module audio_and_iq_serial_ports_asserts (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic [31:0] hrdata_o,
	input wire logic hresp_o,
	input wire logic audio_valid_i,
	input wire logic audio_ready_o,
	input wire logic bb_valid_i,
	input wire logic bb_ready_o,
	input wire logic baseband_bit_clock_o,
	input wire logic baseband_frame_sync_o,
	input wire logic in_phase_serial_out_o,
	input wire logic quadrature_serial_out_o,
	input wire logic baseband_am_mode_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	a_no_wait: assert property (hreadyout_o && !hresp_o)
		else $error("bus slave stalled or erred");
	a_release_quiet: assert property ($fell(reset_i) |-> !baseband_bit_clock_o
		&& !baseband_frame_sync_o && audio_ready_o && bb_ready_o && hrdata_o == 32'h0)
		else $error("outputs not at rest after reset");
	a_audio_take: assert property (audio_valid_i && audio_ready_o |=> !audio_ready_o [*3])
		else $error("audio ready did not stay low after a take");
	a_bb_take: assert property (bb_valid_i && bb_ready_o |=> !bb_ready_o)
		else $error("baseband ready did not drop after a take");
	a_rdata_hold: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i)
		|=> $stable(hrdata_o)) else $error("read data moved without a read");
	a_bb_fs_edge: assert property ($changed(baseband_frame_sync_o)
		|-> $changed(baseband_bit_clock_o)) else $error("frame moved off a bit clock edge");
	a_bb_data_edge: assert property ($changed(in_phase_serial_out_o)
		|| $changed(quadrature_serial_out_o) |-> $changed(baseband_bit_clock_o))
		else $error("baseband data moved off a bit clock edge");
	a_am_by_write: assert property ($changed(baseband_am_mode_o)
		|-> $past(hsel_i && hready_i && htrans_i[1] && hwrite_i, 2))
		else $error("band mode changed without a write");
endmodule
bind audio_and_iq_serial_ports audio_and_iq_serial_ports_asserts chk_u (.clk_sys_i(clk_sys_i),
	.reset_i(reset_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
	.hready_i(hready_i), .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .hresp_o(hresp_o),
	.audio_valid_i(audio_valid_i), .audio_ready_o(audio_ready_o), .bb_valid_i(bb_valid_i),
	.bb_ready_o(bb_ready_o), .baseband_bit_clock_o(baseband_bit_clock_o),
	.baseband_frame_sync_o(baseband_frame_sync_o), .in_phase_serial_out_o(in_phase_serial_out_o),
	.quadrature_serial_out_o(quadrature_serial_out_o), .baseband_am_mode_o(baseband_am_mode_o));
`default_nettype wire

// ### audio_dsp_model.sv
// external audio processor: drives bit clock and frame, records each frame's data bits
`timescale 1ns/1ps
`default_nettype none
module audio_dsp_model (
	input wire logic dsp_i,
	input wire logic left_high_i,
	input wire logic fall_i,
	input wire logic [9:0] len_i,
	input wire logic sdata_i,
	output logic bclk_o,
	output logic fs_o,
	output logic [63:0] frame_o,
	output logic [15:0] frames_o
);
	logic [9:0] cnt = 10'h0;
	logic [63:0] bits = 64'h0;
	logic rise_bit = 1'b0;
	logic [63:0] nb;
	logic [9:0] nc;
	initial begin
		bclk_o = 1'b0;
		fs_o = 1'b0;
		frame_o = 64'h0;
		frames_o = 16'h0;
	end
	// free running bit clock: the device needs it through reset
	always #62.5 bclk_o = ~bclk_o;
	always @(posedge bclk_o) rise_bit <= sdata_i;
	// falling capture: the bit for rising edge p is launched at edge p-1,
	// so it is taken at the falling edge just before edge p
	always @(negedge bclk_o) begin
		nc = (int'(cnt) >= 2 * int'(len_i) - 1) ? 10'h0 : cnt + 10'h1;
		nb = bits;
		if (!fall_i) nb[cnt] = rise_bit;
		if (nc == 10'h0) begin
			frame_o <= nb;
			frames_o <= frames_o + 16'h1;
			nb = 64'h0;
		end
		if (fall_i) nb[nc] = sdata_i;
		bits <= nb;
		cnt <= nc;
		// frame moves on the falling edge so it is settled at the rising one
		fs_o <= dsp_i ? (nc == 10'h0) : ((nc < len_i) ? left_high_i : !left_high_i);
	end
endmodule
`default_nettype wire

// ### audio_and_iq_serial_ports_tb_top.sv
// self-checking bench for the audio and baseband serial ports
`timescale 1ns/1ps
`default_nettype none
module audio_and_iq_serial_ports_tb_top;
	import audio_and_iq_serial_ports_pkg::*;
	logic clk_sys_i = 1'b0, reset_i = 1'b1, hsel = 1'b0, hwrite = 1'b0, a_valid = 1'b0;
	logic b_valid = 1'b0, m_dsp = 1'b0, m_lh = 1'b0, m_fall = 1'b0, bdsp = 1'b0, fs_q = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [23:0] a_left = 24'h0, a_right = 24'h0;
	logic [15:0] b_i = 16'h0, b_q = 16'h0, frames;
	logic [63:0] iw = 64'h0, qw = 64'h0, ib = 64'h0, qb = 64'h0;
	logic bfall = 1'b0;
	logic [9:0] m_len = 10'h20;
	logic [63:0] frame;
	logic [31:0] hrdata;
	logic hready, hresp, a_ready, b_ready, bclk, bfs, in_phase_serial_out, quadrature_serial_out, am, sdo, audio_bit_clock, audio_frame_sync;
	int fail_count = 0, n_checks = 0, cyc = 0, bp = 0, bn = 0, bw = 0, hi_n = 0;
	logic [7:0] ofs [5] = '{OFS_AUDIO_CTRL, OFS_BB_CTRL, OFS_BB_DIV, OFS_BB_LEN, 8'h20};
	logic [31:0] rv [5] = '{{24'h0, AUDIO_CTRL_RST}, {24'h0, BB_CTRL_RST}, {24'h0, BB_DIV_RST},
		{22'h0, BB_LEN_RST}, 32'h0};

	audio_and_iq_serial_ports dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp),
		.audio_bit_clock_i(audio_bit_clock), .audio_frame_sync_i(audio_frame_sync), .audio_serial_out_o(sdo),
		.audio_left_i(a_left), .audio_right_i(a_right), .audio_valid_i(a_valid),
		.audio_ready_o(a_ready), .baseband_bit_clock_o(bclk), .baseband_frame_sync_o(bfs),
		.in_phase_serial_out_o(in_phase_serial_out), .quadrature_serial_out_o(quadrature_serial_out), .bb_in_phase_i(b_i),
		.bb_quadrature_i(b_q), .bb_valid_i(b_valid), .bb_ready_o(b_ready),
		.baseband_am_mode_o(am));
	audio_dsp_model audio_dsp_u (.dsp_i(m_dsp), .left_high_i(m_lh), .fall_i(m_fall),
		.len_i(m_len), .sdata_i(sdo), .bclk_o(audio_bit_clock), .fs_o(audio_frame_sync), .frame_o(frame),
		.frames_o(frames));

	always #10 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			test_done();
		end
	end
	// baseband capture on the selected edge; position counts from the frame event
	always @(bclk) begin
		if (bclk !== bfall) begin
			if (bdsp ? bfs : bfs !== fs_q) begin
				iw = ib;
				qw = qb;
				ib = 64'h0;
				qb = 64'h0;
				bp = 0;
				bn++;
			end else bp++;
			if (bp < 64) begin
				ib[bp] = in_phase_serial_out;
				qb[bp] = quadrature_serial_out;
			end
			if (bfs) hi_n++;
			else if (hi_n != 0) begin
				bw = hi_n;
				hi_n = 0;
			end
			fs_q = bfs;
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic push(input logic bb, input logic [23:0] x, input logic [23:0] y);
		@(posedge clk_sys_i);
		if (bb) begin
			b_i <= x[15:0];
			b_q <= y[15:0];
			b_valid <= 1'b1;
		end else begin
			a_left <= x;
			a_right <= y;
			a_valid <= 1'b1;
		end
		do @(posedge clk_sys_i); while ((bb ? b_ready : a_ready) !== 1'b1);
		a_valid <= 1'b0;
		b_valid <= 1'b0;
	endtask
	// bits of one word at its capture positions within an interval of len edges
	function automatic logic [63:0] exp_word(int f, int len, int w, logic [23:0] x);
		int o;
		exp_word = 64'h0;
		for (int p = 0; p < len; p++) begin
			o = (f == 0 || f == 4) ? p - 1 : (f == 1) ? p : (f == 2) ? p - len + w : p - 2;
			if (o >= 0 && o < w) exp_word[p] = x[w - 1 - o];
		end
	endfunction
	// one frame: two intervals, or one DSP frame with the right word straight after
	function automatic logic [63:0] exp_frame(int f, int len, int w, logic [23:0] l,
		logic [23:0] r);
		if (f >= 3) exp_frame = exp_word(f, 2 * len, w, l) | (exp_word(f, 2 * len, w, r) << w);
		else exp_frame = exp_word(f, len, w, l) | (exp_word(f, len, w, r) << len);
	endfunction

	initial begin
		logic [31:0] q;
		logic [23:0] l;
		logic [23:0] r;
		int w;
		int n0;
		void'($urandom(92531));
		repeat (20) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		foreach (ofs[i]) begin
			bus(1'b0, ofs[i], 32'h0, q);
			check(64'(q), 64'(rv[i]));
		end
		$display("test reset values done");
		for (int f = 0; f < 5; f++) begin
			w = (f % 4 == 0) ? 8 : 12 + 4 * (f % 4);
			l = 24'($urandom) & ((24'h1 << w) - 24'h1);
			r = 24'($urandom) & ((24'h1 << w) - 24'h1);
			m_len <= 10'(26 + $urandom % 7);
			m_dsp <= (f >= 3);
			m_lh <= (f != 0);
			m_fall <= f[0];
			bus(1'b1, OFS_AUDIO_CTRL, 32'(f % 4 * 16 + f % 2 * 8 + f), q);
			bus(1'b0, OFS_AUDIO_CTRL, 32'h0, q);
			check(64'(q), 64'(f % 4 * 16 + f % 2 * 8 + f));
			push(1'b0, l, r);
			n0 = int'(frames);
			while (int'(frames) < n0 + 5) @(posedge clk_sys_i);
			check(frame, exp_frame(f, int'(m_len), w, l, r));
			// by now the pair is taken and the frame length is measured
			bus(1'b0, OFS_STATUS, 32'h0, q);
			check(64'(q), 64'h4);
			$display("test audio format %0d done", f);
		end
		bus(1'b1, OFS_BB_DIV, 32'($urandom % 4 + 1), q);
		for (int f = 0; f < 5; f++) begin
			bdsp <= (f >= 3);
			bfall <= f[0];
			l = 24'($urandom % 65536);
			r = 24'($urandom % 65536);
			// odd formats also take the narrow channel and the falling capture edge
			bus(1'b1, OFS_BB_CTRL, 32'(f % 2 * 136 + 64 + f), q);
			push(1'b1, l, r);
			n0 = bn;
			while (bn < n0 + 5) @(posedge clk_sys_i);
			check(iw, exp_word(f, int'(BB_LEN_RST), BB_WORD_W, l));
			check(qw, exp_word(f, int'(BB_LEN_RST), BB_WORD_W, r));
			check(64'(am), 64'(f % 2));
			if (f >= 3) check(64'(bw), 64'h1);
			$display("test baseband mode %0d done", f);
		end
		test_done();
	end
endmodule
`default_nettype wire
